// file: core/pacw_map.svh
`ifndef PACW_MAP_SVH
`define PACW_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PACW_OFF_DATA 8'h00
`define PACW_OFF_DIR 8'h04
`define PACW_OFF_PDIR 8'h08
`define PACW_OFF_PEN 8'h0c
`define PACW_OFF_IOC 8'h10
`define PACW_OFF_ICTL 8'h14
`define PACW_OFF_OPT 8'h18
`define PACW_OFF_PWR 8'h1c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PACW_BIT_GLB_IE 7
`define PACW_BIT_RAIE 3
`define PACW_BIT_FLAG 0
`define PACW_BIT_GPD 7
`define PACW_BIT_LPWE 5

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define PACW_RST_DIR 6'h3f
`define PACW_RST_PDIR 6'h37
`define PACW_RST_PEN 6'h37
`define PACW_RST_IOC 6'h00
`define PACW_RST_OUT 6'h00
`define PACW_RST_OPT 8'hff
`define PACW_IMPL_PULL 6'h37
`define PACW_PIN3 6'h08
`define PACW_CLK_PINS 6'h30
`define PACW_IRQ_VECTOR 13'h0004

`endif

// file: core/pacw_pkg.sv
package pacw_pkg;

    // static configuration and core state seen by the port
    typedef struct packed {
        logic master_clear_select;
        logic prog_hv;
        logic xtal_mode;
        logic int_osc;
        logic timer_osc;
        logic osc_out;
        logic wake_up_reset_function;
        logic sleep;
    } pacw_cfg_t;

    // apb request as seen by the slave
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pacw_apb_req_t;

endpackage

// file: core/pacw_port.sv
`timescale 1ns/100ps
`include "pacw_map.svh"
// Functional notes
// - pull direction per bit: 1 up, 0 down
// - pull off for output, alternate, gpd, por
// - pull needs gpd clear, input, enable, digital
// - pin three pull-up: reset input, no hv
// - pull enable 5 locked unless int osc without timer osc, 4 locked with osc out; locked bits read 1
// - data reads pins, 7-6 zero, 3 read-only
// - dir 1 input tri-state, 0 drives latch
// - dir 3 reads 1, 5:4 in xtal
// - change enables per pin, cleared at reset
// - mismatch against last read sets flag
// - mismatch keeps setting flag until cleared
// - last-read latch survives warm resets
// - change during port read stays as a mismatch
// - change wakes from sleep, vector if enabled
// - change interrupt only with global enable
// - change enables 5:4 read 0 in xtal
// - change enable 3 ignored: wake reset, asleep
// - wake enable sinks current on pin zero
// - data read pins, write to latch
// - pin three data reads 0 as reset input
module pacw_port (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic WARM_RST_N_I,
    input wire pacw_pkg::pacw_cfg_t CFG_I,
    input wire logic [5:0] ANALOG_I,
    input wire logic [5:0] PAD_I,
    output logic [5:0] PAD_O,
    output logic [5:0] PAD_OE_O,
    output logic [5:0] PULL_UP_O,
    output logic [5:0] PULL_DN_O,
    output logic SINK_O,
    output logic WAKE_O,
    output logic IRQ_O,
    output logic [12:0] VECTOR_O,
    input wire pacw_pkg::pacw_apb_req_t APB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_s1;
    logic rst_n;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // ----------------------------------------------------------------
    // pad synchroniser
    // ----------------------------------------------------------------
    // a change counts only once stages two and three agree
    logic [5:0] pad_s1;
    logic [5:0] pad_s2;
    logic [5:0] pad_s3;
    logic [5:0] pins;

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            pad_s1 <= 6'h00;
            pad_s2 <= 6'h00;
            pad_s3 <= 6'h00;
            pins <= 6'h00;
        end else begin
            pad_s1 <= PAD_I;
            pad_s2 <= pad_s1;
            pad_s3 <= pad_s2;
            for (int i = 0; i < 6; i++) begin
                if (pad_s2[i] == pad_s3[i]) begin
                    pins[i] <= pad_s3[i];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers and derived masks
    // ----------------------------------------------------------------
    logic [5:0] out_latch;
    logic [5:0] dir;
    logic [5:0] pdir;
    logic [5:0] pen;
    logic [5:0] ioc;
    logic [5:0] last_read;
    logic global_interrupt_enable;
    logic raie;
    logic flag;
    logic gpd;
    logic lpwe;
    logic [5:0] clk_mask;
    logic [5:0] alt_mask;
    logic [5:0] dir_eff;
    logic [5:0] pen_lock;
    logic [5:0] pen_eff;
    logic [5:0] ioc_rd;
    logic [5:0] ioc_eff;
    logic [5:0] data_rd;
    logic [5:0] mismatch;

    assign clk_mask = CFG_I.xtal_mode ? `PACW_CLK_PINS :
        {1'b0, CFG_I.osc_out, 4'h0};
    assign alt_mask = ANALOG_I | clk_mask;
    assign dir_eff = dir | `PACW_PIN3 |
        (CFG_I.xtal_mode ? `PACW_CLK_PINS : 6'h00);
    assign pen_lock = {!(CFG_I.int_osc && !CFG_I.timer_osc),
        CFG_I.osc_out, 4'h0};
    assign pen_eff = (pen | pen_lock) & `PACW_IMPL_PULL;
    assign ioc_rd = ioc &
        ~(CFG_I.xtal_mode ? `PACW_CLK_PINS : 6'h00);
    assign ioc_eff = ioc_rd & ~((CFG_I.wake_up_reset_function &&
        CFG_I.sleep) ? `PACW_PIN3 : 6'h00);
    // analog pins read low; pin three reads low as reset input
    assign data_rd = pins & ~ANALOG_I &
        ~(CFG_I.master_clear_select ? `PACW_PIN3 : 6'h00);
    assign mismatch = (pins ^ last_read) & ioc_eff;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    // zero wait states; read data is captured in the setup cycle
    function automatic logic f_hit(input logic [7:0] a,
                                   input logic [7:0] off);
        f_hit = (a == off);
    endfunction

    function automatic logic f_mapped(input logic [7:0] a);
        f_mapped = (a[1:0] == 2'b00) && (a <= `PACW_OFF_PWR);
    endfunction

    logic setup;
    logic acc;
    logic wr;
    logic port_acc;
    logic [5:0] snap;
    logic [31:0] next_prdata;

    assign setup = APB_I.psel && !APB_I.penable;
    assign acc = APB_I.psel && APB_I.penable;
    assign wr = acc && APB_I.pwrite && f_mapped(APB_I.paddr);
    assign port_acc = acc && f_hit(APB_I.paddr, `PACW_OFF_DATA);
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc && !f_mapped(APB_I.paddr);

    always_comb begin
        next_prdata = 32'h0000_0000;
        case (APB_I.paddr)
            `PACW_OFF_DATA: next_prdata[5:0] = data_rd;
            `PACW_OFF_DIR: next_prdata[5:0] = dir_eff;
            `PACW_OFF_PDIR: next_prdata[5:0] = pdir & `PACW_IMPL_PULL;
            `PACW_OFF_PEN: next_prdata[5:0] = pen_eff;
            `PACW_OFF_IOC: next_prdata[5:0] = ioc_rd;
            `PACW_OFF_ICTL: begin
                next_prdata[`PACW_BIT_GLB_IE] = global_interrupt_enable;
                next_prdata[`PACW_BIT_RAIE] = raie;
                next_prdata[`PACW_BIT_FLAG] = flag;
            end
            `PACW_OFF_OPT: next_prdata[`PACW_BIT_GPD] = gpd;
            `PACW_OFF_PWR: next_prdata[`PACW_BIT_LPWE] = lpwe;
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            PRDATA_O <= 32'h0000_0000;
            snap <= 6'h00;
        end else if (setup) begin
            PRDATA_O <= next_prdata;
            snap <= pins;
        end
    end

    // ----------------------------------------------------------------
    // output latch and last-read latch
    // ----------------------------------------------------------------
    // neither is touched by a warm reset
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            out_latch <= `PACW_RST_OUT;
        end else if (wr && f_hit(APB_I.paddr, `PACW_OFF_DATA)) begin
            out_latch <= APB_I.pwdata[5:0] & ~`PACW_PIN3;
        end
    end

    // pins seen in the setup cycle are latched: a change between setup
    // and access then stays behind as a mismatch
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            last_read <= 6'h00;
        end else if (port_acc) begin
            last_read <= snap;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            dir <= `PACW_RST_DIR;
            pdir <= `PACW_RST_PDIR;
            pen <= `PACW_RST_PEN;
            ioc <= `PACW_RST_IOC;
            gpd <= 1'b1;
            lpwe <= 1'b0;
        end else if (!WARM_RST_N_I) begin
            dir <= `PACW_RST_DIR;
            pdir <= `PACW_RST_PDIR;
            pen <= `PACW_RST_PEN;
            ioc <= `PACW_RST_IOC;
            gpd <= 1'b1;
            lpwe <= 1'b0;
        end else if (wr) begin
            case (APB_I.paddr)
                `PACW_OFF_DIR: dir <= APB_I.pwdata[5:0] | `PACW_PIN3;
                `PACW_OFF_PDIR:
                    pdir <= APB_I.pwdata[5:0] & `PACW_IMPL_PULL;
                `PACW_OFF_PEN:
                    pen <= (APB_I.pwdata[5:0] & ~pen_lock) |
                        (pen & pen_lock);
                `PACW_OFF_IOC: ioc <= APB_I.pwdata[5:0];
                `PACW_OFF_OPT: gpd <= APB_I.pwdata[`PACW_BIT_GPD];
                `PACW_OFF_PWR: lpwe <= APB_I.pwdata[`PACW_BIT_LPWE];
                default: lpwe <= lpwe;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt control and change flag
    // ----------------------------------------------------------------
    logic ictl_wr;

    assign ictl_wr = wr && f_hit(APB_I.paddr, `PACW_OFF_ICTL);

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            global_interrupt_enable <= 1'b0;
            raie <= 1'b0;
        end else if (!WARM_RST_N_I) begin
            global_interrupt_enable <= 1'b0;
            raie <= 1'b0;
        end else if (ictl_wr) begin
            global_interrupt_enable <= APB_I.pwdata[`PACW_BIT_GLB_IE];
            raie <= APB_I.pwdata[`PACW_BIT_RAIE];
        end
    end

    // set beats clear, so a live mismatch cannot be cleared away
    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (|mismatch) begin
            flag <= 1'b1;
        end else if (ictl_wr) begin
            flag <= APB_I.pwdata[`PACW_BIT_FLAG];
        end
    end

    // ----------------------------------------------------------------
    // pad drive, pulls, wake
    // ----------------------------------------------------------------
    logic [5:0] pull_on;

    assign pull_on = {6{!gpd}} & dir_eff & pen_eff & ~alt_mask &
        `PACW_IMPL_PULL;

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            PAD_O <= 6'h00;
            PAD_OE_O <= 6'h00;
            PULL_UP_O <= 6'h00;
            PULL_DN_O <= 6'h00;
            SINK_O <= 1'b0;
        end else begin
            PAD_O <= out_latch;
            PAD_OE_O <= ~dir_eff;
            PULL_UP_O <= (pull_on & pdir) |
                ((CFG_I.master_clear_select && !CFG_I.prog_hv) ?
                `PACW_PIN3 : 6'h00);
            PULL_DN_O <= pull_on & ~pdir;
            // the pin must already be an input for a clean discharge
            SINK_O <= lpwe;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            WAKE_O <= 1'b0;
            IRQ_O <= 1'b0;
            VECTOR_O <= 13'h0000;
        end else begin
            WAKE_O <= CFG_I.sleep && flag && raie;
            IRQ_O <= flag && raie && global_interrupt_enable;
            VECTOR_O <= (flag && raie && global_interrupt_enable) ?
                `PACW_IRQ_VECTOR : 13'h0000;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!rst_n);

    a_pull_out_off: assert property (
        ##1 ((PULL_UP_O | PULL_DN_O) & ~$past(dir_eff)) == 6'h00)
        else $error("pull active on an output pin");
    a_pull_gpd_off: assert property (
        gpd |=> ((PULL_UP_O & ~`PACW_PIN3) | PULL_DN_O) == 6'h00)
        else $error("pull active with global disable");
    a_pull_dir_sel: assert property (
        (pull_on[0] && !pdir[0]) |=> PULL_DN_O[0] && !PULL_UP_O[0])
        else $error("pull-down not chosen on pin zero");
    a_pin3_pullup: assert property (
        (CFG_I.master_clear_select && !CFG_I.prog_hv) |=> PULL_UP_O[3])
        else $error("pin three pull-up missing");
    a_dir_pin3_read: assert property (
        (setup && APB_I.paddr == `PACW_OFF_DIR) |=> PRDATA_O[3])
        else $error("direction bit three read as zero");
    a_ioc_xtal_read: assert property (
        (setup && APB_I.paddr == `PACW_OFF_IOC && CFG_I.xtal_mode)
        |=> PRDATA_O[5:4] == 2'b00)
        else $error("change enables 5:4 visible in xtal mode");
    a_data_upper: assert property (
        (setup && APB_I.paddr == `PACW_OFF_DATA) |=> PRDATA_O[7:6] == 2'b00)
        else $error("data bits 7:6 not zero");
    a_flag_set: assert property (
        (|mismatch) |=> flag [*2])
        else $error("mismatch did not hold the flag");
    a_latch_load: assert property (
        port_acc |=> last_read == $past(snap))
        else $error("last-read latch not loaded");
    a_pen5_lock: assert property (
        (wr && APB_I.paddr == `PACW_OFF_PEN && pen_lock[5])
        |=> $stable(pen[5]))
        else $error("locked pull enable changed");
    a_irq_global_en: assert property (
        IRQ_O |-> $past(global_interrupt_enable))
        else $error("interrupt without global enable");
    a_wake_sleep: assert property (
        (CFG_I.sleep && flag && raie) |=> WAKE_O)
        else $error("no wake on change in sleep");
    a_sink_follow: assert property (
        $rose(lpwe) |=> SINK_O)
        else $error("current sink not enabled");
    a_oe_dir: assert property (
        ##1 PAD_OE_O == ~$past(dir_eff))
        else $error("driver enable disagrees with direction");

    c_flag_set: cover property ($rose(flag));
    c_wake: cover property ($rose(WAKE_O));
    c_irq: cover property ($rose(IRQ_O));
    c_port_write: cover property (wr && APB_I.paddr == `PACW_OFF_DATA);

endmodule

// file: dv/pacw_pins.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// board pins: drivers, weak pulls, rc network on pin zero
// ----------------------------------------------------------------
module pacw_pins (
    input wire logic clk_i,
    input wire logic [5:0] out_i,
    input wire logic [5:0] oe_i,
    input wire logic [5:0] up_i,
    input wire logic [5:0] dn_i,
    input wire logic sink_i,
    input wire logic [5:0] ext_en_i,
    input wire logic [5:0] ext_lvl_i,
    output logic [5:0] lvl_o
);
    // floating pins wander so a stale value never looks valid
    logic [5:0] wild = 6'h15;
    logic [7:0] cap = 8'h00;

    always_ff @(posedge clk_i) begin
        wild <= ~wild;
        if (oe_i[0] && out_i[0]) begin
            cap <= 8'hff;
        end else if (sink_i && cap != 8'h00) begin
            cap <= cap - 8'h01;
        end
    end

    // cap on pin zero outweighs the weak pulls
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (oe_i[i]) begin
                lvl_o[i] = out_i[i];
            end else if (ext_en_i[i]) begin
                lvl_o[i] = ext_lvl_i[i];
            end else if (i == 0) begin
                lvl_o[i] = cap[7];
            end else if (up_i[i] || dn_i[i]) begin
                lvl_o[i] = up_i[i];
            end else begin
                lvl_o[i] = wild[i];
            end
        end
    end
endmodule

// file: dv/port_a_pull_change_wake_tb.sv
`timescale 1ns/100ps
`include "pacw_map.svh"
module port_a_pull_change_wake_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic warm_n = 1'b1;
    pacw_pkg::pacw_cfg_t cfg = 8'h90;
    pacw_pkg::pacw_apb_req_t req = '0;
    logic [5:0] ana = 6'h00;
    logic [5:0] ext_en = 6'h0a;
    logic [5:0] ext_lvl = 6'h00;
    logic [5:0] lvl, pad_o, oe, up, dn;
    logic sink, wake, irq, pready, pslverr, err;
    logic [12:0] vec;
    logic [31:0] prdata, rdat;
    int bad_count = 0;
    int checks_done = 0;
    int n;

    always #2 clk = ~clk;

    pacw_port dut (.REF_CLK_I(clk), .RST_N_I(rst_n), .WARM_RST_N_I(warm_n),
        .CFG_I(cfg), .ANALOG_I(ana), .PAD_I(lvl), .PAD_O(pad_o),
        .PAD_OE_O(oe), .PULL_UP_O(up), .PULL_DN_O(dn), .SINK_O(sink),
        .WAKE_O(wake), .IRQ_O(irq), .VECTOR_O(vec), .APB_I(req),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr));

    pacw_pins pins (.clk_i(clk), .out_i(pad_o), .oe_i(oe), .up_i(up),
        .dn_i(dn), .sink_i(sink), .ext_en_i(ext_en), .ext_lvl_i(ext_lvl),
        .lvl_o(lvl));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // apb master: hold the request until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        err = pslverr;
        req <= '0;
        if (pready !== 1'b1) begin
            bad_count++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        tick(3);
        rst_n <= 1'b1;
        tick(5);
        rdc(`PACW_OFF_DIR, 32'hff, 32'h3f);
        rdc(`PACW_OFF_PDIR, 32'hff, 32'h37);
        rdc(`PACW_OFF_PEN, 32'hff, 32'h37);
        rdc(`PACW_OFF_IOC, 32'hff, 32'h00);
        rdc(`PACW_OFF_OPT, 32'hff, 32'h80);
        xfer(1'b0, 8'h20, 32'h0);
        chk({err, rdat[30:0]}, 32'h80000000);
        $display("test reset done");

        wr(`PACW_OFF_DATA, 32'h15);
        wr(`PACW_OFF_DIR, 32'h00);
        rdc(`PACW_OFF_DIR, 32'hff, 32'h08);
        tick(8);
        chk(oe, 32'h37);
        rdc(`PACW_OFF_DATA, 32'hff, 32'h15);
        ana <= 6'h04;
        rdc(`PACW_OFF_DATA, 32'hff, 32'h11);
        ana <= 6'h00;
        wr(`PACW_OFF_DATA, 32'hff);
        tick(8);
        chk(pad_o, 32'h37);
        rdc(`PACW_OFF_DATA, 32'hffff, 32'h37);
        wr(`PACW_OFF_DIR, 32'h3f);
        $display("test direction done");

        ana <= 6'h02;
        wr(`PACW_OFF_OPT, 32'h00);
        wr(`PACW_OFF_PDIR, 32'h05);
        tick(3);
        chk(up, 32'h0d);
        chk(dn, 32'h30);
        wr(`PACW_OFF_DIR, 32'h3e);
        cfg.prog_hv <= 1'b1;
        tick(3);
        chk(up, 32'h04);
        wr(`PACW_OFF_OPT, 32'h80);
        tick(3);
        chk({up, dn}, 32'h0);
        wr(`PACW_OFF_DIR, 32'h3f);
        cfg.prog_hv <= 1'b0;
        ana <= 6'h00;
        $display("test pulls done");

        cfg.osc_out <= 1'b1;
        cfg.timer_osc <= 1'b1;
        wr(`PACW_OFF_PEN, 32'h00);
        rdc(`PACW_OFF_PEN, 32'hff, 32'h30);
        cfg.osc_out <= 1'b0;
        cfg.timer_osc <= 1'b0;
        wr(`PACW_OFF_PEN, 32'h00);
        rdc(`PACW_OFF_PEN, 32'hff, 32'h00);
        cfg.xtal_mode <= 1'b1;
        wr(`PACW_OFF_DIR, 32'h00);
        rdc(`PACW_OFF_DIR, 32'hff, 32'h38);
        wr(`PACW_OFF_IOC, 32'h3f);
        rdc(`PACW_OFF_IOC, 32'hff, 32'h0f);
        cfg.xtal_mode <= 1'b0;
        wr(`PACW_OFF_DIR, 32'h3f);
        // let the released pins pass the synchroniser before the read
        tick(8);
        $display("test locks done");

        wr(`PACW_OFF_IOC, 32'h02);
        rdc(`PACW_OFF_DATA, 32'h0, 32'h0);
        wr(`PACW_OFF_ICTL, 32'h88);
        tick(8);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h00);
        ext_lvl[1] <= 1'b1;
        tick(8);
        chk(irq, 32'h1);
        chk(vec, `PACW_IRQ_VECTOR);
        wr(`PACW_OFF_ICTL, 32'h88);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h01);
        rdc(`PACW_OFF_DATA, 32'h02, 32'h02);
        wr(`PACW_OFF_ICTL, 32'h88);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h00);
        wr(`PACW_OFF_ICTL, 32'h08);
        ext_lvl[1] <= 1'b0;
        tick(8);
        chk({irq, vec}, 32'h0);
        cfg.sleep <= 1'b1;
        tick(3);
        chk(wake, 32'h1);
        cfg.sleep <= 1'b0;
        warm_n <= 1'b0;
        tick(2);
        warm_n <= 1'b1;
        tick(2);
        wr(`PACW_OFF_ICTL, 32'h00);
        rdc(`PACW_OFF_IOC, 32'hff, 32'h00);
        wr(`PACW_OFF_IOC, 32'h02);
        tick(4);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h01);
        wr(`PACW_OFF_DATA, 32'h00);
        wr(`PACW_OFF_ICTL, 32'h00);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h00);
        cfg.wake_up_reset_function <= 1'b1;
        cfg.sleep <= 1'b1;
        ext_lvl[3] <= 1'b1;
        wr(`PACW_OFF_IOC, 32'h08);
        tick(8);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h00);
        cfg.sleep <= 1'b0;
        tick(2);
        rdc(`PACW_OFF_ICTL, 32'h01, 32'h01);
        cfg.master_clear_select <= 1'b0;
        rdc(`PACW_OFF_DATA, 32'h08, 32'h08);
        chk(up[3], 32'h0);
        cfg.master_clear_select <= 1'b1;
        cfg.wake_up_reset_function <= 1'b0;
        ext_lvl[3] <= 1'b0;
        $display("test change done");

        // charge, arm, discharge: the cap sets the wake delay
        wr(`PACW_OFF_DATA, 32'h01);
        wr(`PACW_OFF_DIR, 32'h3e);
        tick(2);
        wr(`PACW_OFF_IOC, 32'h01);
        wr(`PACW_OFF_DIR, 32'h3f);
        rdc(`PACW_OFF_DATA, 32'h01, 32'h01);
        wr(`PACW_OFF_ICTL, 32'h08);
        wr(`PACW_OFF_PWR, 32'h20);
        tick(2);
        chk(sink, 32'h1);
        cfg.sleep <= 1'b1;
        n = 0;
        while (wake !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
        chk(wake, 32'h1);
        chk(irq, 32'h0);
        $display("test wake done");
        give_verdict();
    end
endmodule
